// file: logic/mctr_lvl_mem.sv
/*
  Small per-channel level table: one write port, two registered read
  ports. Assumes writes and reads in the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module mctr_lvl_mem #(
  parameter int DW = 32,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [DW-1:0] rdata_a,
  output logic [DW-1:0] rdata_b
);
  logic [DW-1:0] mem [DEPTH];

  // Write port; no reset so it maps onto RAM
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered reads, one cycle latency
  always_ff @(posedge pclk) begin
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule
`default_nettype wire

// file: logic/mctr_top.sv
/*
  Multichannel trigger evaluator: per-channel level/edge/latched trigger
  tests on scanned samples, AND/OR combination, masked digital pattern
  trigger, change-of-state events and the alarm relay drive.
  Assumes samples arrive synchronous to pclk, one channel per strobe,
  with samp_last marking the last channel of a scan; APB slave access.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Above-level channel valid while sample exceeds level, cleared below it.
// - OR mode starts acquisition when any enabled channel is valid and ready.
// - AND mode starts only when all enabled channels are valid together.
// - Below-level channel valid while sample under level, cleared above it.
// - Above-level latched channel stays set until acquisition done and re-arm.
// - Below-level latched channel stays set until acquisition done and re-arm.
// - In AND mode a dropped instantaneous channel counts only once valid again.
// - Every channel has its own trigger type, freely mixed.
// - Rising edge: valid above threshold after below band; invalid below band.
// - Edge channel already past threshold waits for a band crossing first.
// - Falling edge: valid below threshold after above band; invalid above band.
// - Rising-edge latched arms like rising edge, then stays valid.
// - Falling-edge latched validates like falling edge, then stays valid.
// - Masked 16-bit pattern compared with digital inputs starts collection.
// - Equal polarity fires when all unmasked bits match the pattern.
// - Not-equal polarity fires when unmasked bits change after a match.
// - A set mask bit removes that input bit from comparison.
// - Up to 16 inputs flag change-of-state or pattern events.
// - Relay energized while triggered recording runs, when enabled.
// - Triggers while not ready are ignored without any indication.
module mctr_top
  import mctr_pkg::*;
#(
  parameter int NCH = 8,
  parameter int CW = 3,
  parameter int SW = 16,
  parameter int DW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic samp_valid,
  input wire logic [CW-1:0] samp_chan,
  input wire logic signed [SW-1:0] samp_data,
  input wire logic samp_last,
  input wire logic [DW-1:0] din,
  output logic acq_start,
  output logic acq_active,
  output logic relay_on,
  output logic event_pulse
);
  mctr_state_t state_q;
  logic [MCTR_CTRL_W-1:0] ctrl_q;
  logic [3*NCH-1:0] type_q;
  logic [NCH-1:0] chen_q, valid_q, armed_q;
  logic [DW-1:0] dpat_q, dmsk_q, din_q;
  logic [1:0] evt_q;
  logic pmatch_q, s_v_q, s_last_q, comb_q, relay_q, evp_q;
  logic [CW-1:0] s_chan_q;
  logic signed [SW-1:0] s_data_q;
  logic [31:0] lvl_a, lvl_b;
  logic wr, rd, arm_cmd, done_cmd, lvl_hit, mc_hit, pat_hit, fire;
  logic pmatch, cos_chg;
  logic signed [SW+1:0] thr, hi_band, lo_band, smp;

  // APB decode; zero wait states, level table read in the setup cycle
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign lvl_hit = paddr[7:6] == MCTR_OFF_LVL[7:6];
  assign arm_cmd = wr & (paddr == MCTR_OFF_CTRL) & pwdata[MCTR_CTRL_ARM];
  assign done_cmd = wr & (paddr == MCTR_OFF_DONE) & pwdata[0];

  mctr_lvl_mem #(
    .DW(32),
    .DEPTH(NCH),
    .AW(CW)
  ) u_lvl (
    .pclk(pclk),
    .we(wr & lvl_hit),
    .waddr(paddr[CW+1:2]),
    .wdata(pwdata),
    .raddr_a(samp_chan),
    .raddr_b(paddr[CW+1:2]),
    .rdata_a(lvl_a),
    .rdata_b(lvl_b)
  );

  // Read mux and error on unmapped offsets
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (lvl_hit) begin
      prdata = lvl_b;
    end else begin
      case (paddr)
        MCTR_OFF_CTRL: prdata = {24'h00_0000, ctrl_q};
        MCTR_OFF_STAT: prdata = {7'h00, pmatch_q, valid_q, armed_q,
                                 5'h00, state_q};
        MCTR_OFF_TYPE: prdata = {8'h00, type_q};
        MCTR_OFF_CHEN: prdata = {24'h00_0000, chen_q};
        MCTR_OFF_DPAT: prdata = {16'h0000, dpat_q};
        MCTR_OFF_DMSK: prdata = {16'h0000, dmsk_q};
        MCTR_OFF_DONE: prdata = 32'h0000_0000;
        MCTR_OFF_EVT: prdata = {30'h0000_0000, evt_q};
        default: pslverr = psel & penable;
      endcase
    end
  end

  // Configuration registers; the arm bit never stores, it only pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= MCTR_CTRL_RST;
      type_q <= '0;
      chen_q <= '0;
      dpat_q <= MCTR_DPAT_RST;
      dmsk_q <= MCTR_DMSK_RST;
    end else if (wr) begin
      case (paddr)
        MCTR_OFF_CTRL: ctrl_q <= pwdata[MCTR_CTRL_W-1:0] & 8'hFE;
        MCTR_OFF_TYPE: type_q <= pwdata[3*NCH-1:0];
        MCTR_OFF_CHEN: chen_q <= pwdata[NCH-1:0];
        MCTR_OFF_DPAT: dpat_q <= pwdata[DW-1:0];
        MCTR_OFF_DMSK: dmsk_q <= pwdata[DW-1:0];
        default: ;
      endcase
    end
  end

  // Acquisition control: idle until armed, ready, then recording
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MCTR_IDLE;
    end else begin
      case (state_q)
        MCTR_IDLE: if (arm_cmd) state_q <= MCTR_READY;
        MCTR_READY: if (fire) state_q <= MCTR_ACQ;
        MCTR_ACQ: if (done_cmd) state_q <= MCTR_IDLE;
        default: state_q <= MCTR_IDLE;
      endcase
    end
  end

  // Sample stage aligned with the registered level read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_v_q <= 1'b0;
      s_last_q <= 1'b0;
      s_chan_q <= '0;
      s_data_q <= '0;
      comb_q <= 1'b0;
    end else begin
      s_v_q <= samp_valid;
      s_last_q <= samp_valid & samp_last;
      s_chan_q <= samp_chan;
      s_data_q <= samp_data;
      comb_q <= s_last_q; // Combine once the whole scan is updated
    end
  end

  // Threshold in the low half, hysteresis band width in the high half
  assign thr = {{2{lvl_a[SW-1]}}, lvl_a[SW-1:0]};
  assign smp = {{2{s_data_q[SW-1]}}, s_data_q};
  assign hi_band = thr + $signed({2'b00, lvl_a[16+SW-1:16]});
  assign lo_band = thr - $signed({2'b00, lvl_a[16+SW-1:16]});

  // Per-channel evaluation, one update per channel per scan
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic edge_t, latch_t, below_t, cond, past_band, hit;
    assign edge_t = type_q[3*i+2];
    assign latch_t = type_q[3*i+1];
    assign below_t = type_q[3*i];
    assign cond = below_t ? (smp < thr) : (smp > thr);
    assign past_band = below_t ? (smp > hi_band) : (smp < lo_band);
    assign hit = s_v_q & (s_chan_q == CW'(i));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        valid_q[i] <= 1'b0;
        armed_q[i] <= 1'b0;
      end else if (arm_cmd) begin
        valid_q[i] <= 1'b0;
        armed_q[i] <= 1'b0;
      end else if (hit && state_q == MCTR_READY) begin
        if (!edge_t) begin
          valid_q[i] <= latch_t ? (valid_q[i] | cond) : cond;
        end else if (past_band) begin
          armed_q[i] <= 1'b1;
          if (!latch_t) begin
            valid_q[i] <= 1'b0;
          end
        end else if (armed_q[i] && cond) begin
          valid_q[i] <= 1'b1;
        end
      end
    end
  end

  // Channel combination, evaluated after the scan completes
  always_comb begin
    if (ctrl_q[MCTR_CTRL_AND]) begin
      mc_hit = (&(valid_q | ~chen_q)) & (|chen_q);
    end else begin
      mc_hit = |(valid_q & chen_q);
    end
  end

  // Pattern compare with masked bits excluded
  assign pmatch = ((din ^ dpat_q) & ~dmsk_q) == '0;
  assign cos_chg = ((din ^ din_q) & ~dmsk_q) != '0;
  assign pat_hit = ctrl_q[MCTR_CTRL_NEQ] ? (pmatch_q & ~pmatch)
                                         : pmatch;
  // Only the ready state lets a trigger through; others drop it silently
  assign fire = (state_q == MCTR_READY) &
                ((ctrl_q[MCTR_CTRL_MC] & comb_q & mc_hit) |
                 (ctrl_q[MCTR_CTRL_PAT] & pat_hit));

  // Input history for pattern polarity and change detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_q <= '0;
      pmatch_q <= 1'b0;
    end else begin
      din_q <= din;
      pmatch_q <= pmatch;
    end
  end

  // Sticky events; a new event beats a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 2'b00;
      evp_q <= 1'b0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (wr && paddr == MCTR_OFF_EVT && pwdata[b]) begin
          evt_q[b] <= 1'b0;
        end
      end
      if (ctrl_q[MCTR_CTRL_COS] && cos_chg) begin
        evt_q[MCTR_EVT_COS] <= 1'b1;
      end
      if (ctrl_q[MCTR_CTRL_PEV] && pmatch && !pmatch_q) begin
        evt_q[MCTR_EVT_PAT] <= 1'b1;
      end
      evp_q <= (ctrl_q[MCTR_CTRL_COS] & cos_chg) |
               (ctrl_q[MCTR_CTRL_PEV] & pmatch & ~pmatch_q);
    end
  end

  // Relay follows recording one clock late, so it drops the cycle after the run ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_q <= 1'b0;
    end else begin
      relay_q <= ctrl_q[MCTR_CTRL_RLY] & (state_q == MCTR_ACQ);
    end
  end

  assign acq_start = fire;
  assign acq_active = state_q == MCTR_ACQ;
  assign relay_on = relay_q;
  assign event_pulse = evp_q;

  property p_ready_only;
    @(posedge pclk) disable iff (!presetn)
      acq_start |=> !acq_start;
  endproperty
  a_ready_only: assert property (p_ready_only)
    else $error("trigger taken while not ready");

  property p_start_acq;
    @(posedge pclk) disable iff (!presetn)
      acq_start |=> acq_active;
  endproperty
  a_start_acq: assert property (p_start_acq)
    else $error("acquisition did not start after trigger");

  property p_and_all;
    @(posedge pclk) disable iff (!presetn)
      (acq_start && ctrl_q[MCTR_CTRL_AND] && !ctrl_q[MCTR_CTRL_PAT])
        |-> (valid_q & chen_q) == chen_q;
  endproperty
  a_and_all: assert property (p_and_all)
    else $error("AND trigger with an invalid channel");

  property p_or_any;
    @(posedge pclk) disable iff (!presetn)
      (state_q == MCTR_READY && ctrl_q[MCTR_CTRL_MC] && comb_q &&
       !ctrl_q[MCTR_CTRL_AND] && (valid_q & chen_q) != '0) |-> acq_start;
  endproperty
  a_or_any: assert property (p_or_any)
    else $error("OR trigger missed a valid channel");

  property p_latch_hold;
    @(posedge pclk) disable iff (!presetn)
      (valid_q[0] && type_q[1] && !arm_cmd) |=> valid_q[0];
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched channel dropped");

  property p_edge_needs_arm;
    @(posedge pclk) disable iff (!presetn)
      ($rose(valid_q[0]) && type_q[2]) |-> $past(armed_q[0]);
  endproperty
  a_edge_needs_arm: assert property (p_edge_needs_arm)
    else $error("edge channel valid without band crossing");

  property p_rearm_clear;
    @(posedge pclk) disable iff (!presetn)
      arm_cmd |=> valid_q == '0 && armed_q == '0;
  endproperty
  a_rearm_clear: assert property (p_rearm_clear)
    else $error("arming state survived re-arm");

  property p_eq_fire;
    @(posedge pclk) disable iff (!presetn)
      (state_q == MCTR_READY && ctrl_q[MCTR_CTRL_PAT] &&
       !ctrl_q[MCTR_CTRL_NEQ] && ((din ^ dpat_q) & ~dmsk_q) == '0)
        |-> acq_start;
  endproperty
  a_eq_fire: assert property (p_eq_fire)
    else $error("pattern match did not trigger");

  property p_relay;
    @(posedge pclk) disable iff (!presetn)
      relay_on |-> $past(acq_active) && $past(ctrl_q[MCTR_CTRL_RLY]);
  endproperty
  a_relay: assert property (p_relay)
    else $error("relay on outside enabled recording");

  c_or_start: cover property (@(posedge pclk) disable iff (!presetn)
    acq_start && !ctrl_q[MCTR_CTRL_AND]);
  c_and_start: cover property (@(posedge pclk) disable iff (!presetn)
    acq_start && ctrl_q[MCTR_CTRL_AND]);
  c_pat_neq: cover property (@(posedge pclk) disable iff (!presetn)
    acq_start && ctrl_q[MCTR_CTRL_NEQ]);
endmodule
`default_nettype wire

// file: shared/mctr_pkg.sv
/*
  Shared constants of the multichannel trigger evaluator: register map,
  field positions, reset values, trigger types and control states.
  Assumes a 32-bit APB with byte addresses and word-aligned registers.
*/
package mctr_pkg;
  // Register byte offsets
  localparam logic [7:0] MCTR_OFF_CTRL = 8'h00;
  localparam logic [7:0] MCTR_OFF_STAT = 8'h04;
  localparam logic [7:0] MCTR_OFF_TYPE = 8'h08;
  localparam logic [7:0] MCTR_OFF_CHEN = 8'h0C;
  localparam logic [7:0] MCTR_OFF_DPAT = 8'h10;
  localparam logic [7:0] MCTR_OFF_DMSK = 8'h14;
  localparam logic [7:0] MCTR_OFF_DONE = 8'h18;
  localparam logic [7:0] MCTR_OFF_EVT = 8'h1C;
  localparam logic [7:0] MCTR_OFF_LVL = 8'h40; // Level table, one word/chan
  // CTRL field positions
  localparam int MCTR_CTRL_ARM = 0;  // Write 1: re-arm (self clearing)
  localparam int MCTR_CTRL_AND = 1;  // 1 = AND, 0 = OR combination
  localparam int MCTR_CTRL_RLY = 2;  // Alarm relay enable
  localparam int MCTR_CTRL_PAT = 3;  // Pattern trigger enable
  localparam int MCTR_CTRL_NEQ = 4;  // Pattern polarity: 1 = not equal
  localparam int MCTR_CTRL_MC = 5;   // Multichannel trigger enable
  localparam int MCTR_CTRL_COS = 6;  // Event on change of state
  localparam int MCTR_CTRL_PEV = 7;  // Event on pattern recognition
  localparam int MCTR_CTRL_W = 8;
  localparam logic [MCTR_CTRL_W-1:0] MCTR_CTRL_RST = 8'h00;
  // EVT sticky bits
  localparam int MCTR_EVT_COS = 0;
  localparam int MCTR_EVT_PAT = 1;
  // Reset values of config words
  localparam logic [15:0] MCTR_DPAT_RST = 16'h0000;
  localparam logic [15:0] MCTR_DMSK_RST = 16'hFFFF;
  // Trigger type: bit2 edge, bit1 latched, bit0 below/falling
  typedef enum logic [2:0] {
    MCTR_ABOVE = 3'h0,
    MCTR_BELOW = 3'h1,
    MCTR_ABOVE_L = 3'h2,
    MCTR_BELOW_L = 3'h3,
    MCTR_RISE = 3'h4,
    MCTR_FALL = 3'h5,
    MCTR_RISE_L = 3'h6,
    MCTR_FALL_L = 3'h7
  } mctr_type_t;
  // Acquisition control states, one-hot
  typedef enum logic [2:0] {
    MCTR_IDLE = 3'b001,
    MCTR_READY = 3'b010,
    MCTR_ACQ = 3'b100
  } mctr_state_t;
endpackage

// file: tb/mctr_src_model.sv
/*
  Partner model: scanned sample source for channels 0 and 1.
  Assumes go is a one-cycle request from the bench, synchronous to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module mctr_src_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [1:0] gap,
  input wire logic [15:0] v0,
  input wire logic [15:0] v1,
  output logic samp_valid,
  output logic [2:0] samp_chan,
  output logic signed [15:0] samp_data,
  output logic samp_last,
  output logic busy
);
  logic idx_q;
  logic [1:0] wait_q;

  // One scan is channel 0 then channel 1; gap idles a slow converter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_valid <= 1'b0;
      samp_chan <= 3'h0;
      samp_data <= 16'h5A5A;
      samp_last <= 1'b0;
      busy <= 1'b0;
      idx_q <= 1'b0;
      wait_q <= 2'h0;
    end else begin
      samp_valid <= 1'b0;
      samp_last <= 1'b0;
      // Off-strobe data toggles so a stale sample can never look valid
      samp_data <= ~samp_data;
      if (go && !busy) begin
        busy <= 1'b1;
        idx_q <= 1'b0;
        wait_q <= gap;
      end else if (busy && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (busy) begin
        samp_valid <= 1'b1;
        samp_chan <= {2'b00, idx_q};
        samp_data <= idx_q ? v1 : v0;
        samp_last <= idx_q;
        idx_q <= 1'b1;
        wait_q <= gap;
        busy <= ~idx_q;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
/*
  Self-checking bench: APB configuration, scans from the sample model,
  digital input patterns and events, counted acquisition starts.
  Assumes the design answers APB with pready and levels are thr 100, band 20.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mctr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, go, pready, pslverr, ev;
  logic samp_valid, samp_last, busy, acq_start, acq_active;
  logic relay_on, event_pulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, starts, exp_st, evs;
  logic [2:0] samp_chan;
  logic signed [15:0] samp_data;
  logic [15:0] din, v0, v1;
  logic [1:0] gap;
  int errors, total_checks;

  mctr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .samp_valid, .samp_chan, .samp_data,
    .samp_last, .din, .acq_start, .acq_active, .relay_on, .event_pulse);
  mctr_src_model src (.pclk, .presetn, .go, .gap, .v0, .v1, .samp_valid,
    .samp_chan, .samp_data, .samp_last, .busy);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Pulses are counted at the edge that samples them
  always @(posedge pclk) begin
    if (acq_start === 1'b1) starts <= starts + 32'h1;
    if (event_pulse === 1'b1) evs <= evs + 32'h1;
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; an idle edge after it keeps psel from double drive
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      close_out();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic cfg(input logic [7:0] c, t, ch);
    apb(1'b1, MCTR_OFF_TYPE, {24'h0000_00, t});
    apb(1'b1, MCTR_OFF_CHEN, {24'h0000_00, ch});
    apb(1'b1, MCTR_OFF_CTRL, {24'h0000_00, c | 8'h01});
  endtask

  // Extra edge lets the registered relay follow the state change
  task automatic done_acq;
    apb(1'b1, MCTR_OFF_DONE, 32'h0000_0001);
    @(posedge pclk);
  endtask

  task automatic settle(input int f);
    repeat (5) @(posedge pclk);
    exp_st = exp_st + f;
    chk("starts", starts, exp_st);
  endtask

  task automatic sc(input int a, b, f);
    int n;
    v0 <= a[15:0];
    v1 <= b[15:0];
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy !== 1'b0 && n < 40);
    if (busy !== 1'b0) begin
      errors++;
      close_out();
    end
    settle(f);
  endtask

  task automatic dv(input logic [15:0] v, input int f);
    din <= v;
    settle(f);
  endtask

  initial begin
    {psel, penable, pwrite, go, presetn} = 5'b00000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {din, v0, v1, gap} = {16'h12A4, 16'h0000, 16'h0000, 2'b00};
    {starts, exp_st, evs} = {32'h0, 32'h0, 32'h0};
    errors = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, MCTR_OFF_CTRL, 32'h0000_0000);
    chk("ctrl", rv, 32'h0000_0000);
    apb(1'b0, MCTR_OFF_STAT, 32'h0000_0000);
    chk("state", {29'h0, rv[2:0]}, 32'h0000_0001);
    apb(1'b0, MCTR_OFF_DMSK, 32'h0000_0000);
    chk("mask", rv, 32'h0000_FFFF);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk("slverr", {31'h0, ev}, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, MCTR_OFF_LVL + 8'(4 * i), 32'h0014_0064);
    end
    apb(1'b0, MCTR_OFF_LVL + 8'h0C, 32'h0000_0000);
    chk("level", rv, 32'h0014_0064);
    // OR mode, above and below level, relay on while recording
    cfg(8'h24, 8'h08, 8'h03);
    sc(50, 150, 0);
    sc(150, 150, 1);
    apb(1'b0, MCTR_OFF_STAT, 32'h0000_0000);
    chk("state", {29'h0, rv[2:0]}, 32'h0000_0004);
    chk("active", {31'h0, acq_active}, 32'h0000_0001);
    chk("relay", {31'h0, relay_on}, 32'h0000_0001);
    sc(150, 50, 0);
    done_acq();
    chk("relay", {31'h0, relay_on}, 32'h0000_0000);
    chk("active", {31'h0, acq_active}, 32'h0000_0000);
    // AND mode with instantaneous channels
    cfg(8'h22, 8'h08, 8'h03);
    sc(150, 150, 0);
    sc(50, 50, 0);
    sc(150, 50, 1);
    done_acq();
    // Latched above level mixed with below level, then re-arm clears it
    cfg(8'h22, 8'h0A, 8'h03);
    sc(150, 150, 0);
    sc(50, 150, 0);
    sc(50, 50, 1);
    done_acq();
    cfg(8'h22, 8'h0A, 8'h03);
    sc(50, 50, 0);
    sc(150, 50, 1);
    done_acq();
    // Rising edge must see the band first
    cfg(8'h20, 8'h04, 8'h01);
    sc(150, 0, 0);
    sc(90, 0, 0);
    sc(150, 0, 0);
    sc(70, 0, 0);
    sc(150, 0, 1);
    done_acq();
    // Falling edge
    cfg(8'h20, 8'h05, 8'h01);
    sc(50, 0, 0);
    sc(130, 0, 0);
    sc(90, 0, 1);
    done_acq();
    // Rising edge loses validity below the band under AND
    cfg(8'h22, 8'h0C, 8'h03);
    sc(70, 150, 0);
    sc(150, 150, 0);
    sc(70, 50, 0);
    sc(150, 50, 1);
    done_acq();
    // Latched edges with a slow sample source
    gap <= 2'h2;
    cfg(8'h22, 8'h3E, 8'h03);
    sc(70, 130, 0);
    sc(150, 130, 0);
    sc(70, 50, 1);
    done_acq();
    // Pattern trigger, equal then not equal, upper byte masked
    apb(1'b1, MCTR_OFF_DPAT, 32'h0000_00A5);
    apb(1'b1, MCTR_OFF_DMSK, 32'h0000_FF00);
    cfg(8'h08, 8'h00, 8'h00);
    dv(16'h12A4, 0);
    dv(16'h34A5, 1);
    done_acq();
    cfg(8'h18, 8'h00, 8'h00);
    dv(16'h77A5, 0);
    dv(16'h77A7, 1);
    done_acq();
    // Change of state and pattern events
    cfg(8'h40, 8'h00, 8'h00);
    dv(16'h77A6, 0);
    chk("events", evs, 32'h0000_0001);
    apb(1'b0, MCTR_OFF_EVT, 32'h0000_0000);
    chk("evt_cos", {31'h0, rv[0]}, 32'h0000_0001);
    cfg(8'h80, 8'h00, 8'h00);
    dv(16'h11A5, 0);
    chk("events", evs, 32'h0000_0002);
    apb(1'b0, MCTR_OFF_EVT, 32'h0000_0000);
    chk("evt_pat", {31'h0, rv[1]}, 32'h0000_0001);
    apb(1'b1, MCTR_OFF_EVT, 32'h0000_0003);
    apb(1'b0, MCTR_OFF_EVT, 32'h0000_0000);
    chk("evt_clr", rv, 32'h0000_0000);
    close_out();
  end
endmodule
`default_nettype wire
